// File: logic/frha_regs.vh
// What this block does
// [R1] Low sixteen address bits in address-low register
// [R2] Upper four address bits in control bits 3..0
// [R3] Select 0 routes to ROM, 1 to flash
// [R4] Same select picks configuration download source
// [R5] Writing strobe 1 stores data byte
// [R6] Data byte at 15..8, reads back store; while a store write runs the code returns data_byte_r instead
// [R7] User software leaves these fields alone
// [R8] Download-mode bits stored, no effect
// [R9] Set fields before strobe, hold until done
`ifndef FRHA_REGS_VH
`define FRHA_REGS_VH
`define FRHA_ADDR_LOW_OFS 12'h000
`define FRHA_CONTROL_OFS 12'h004
`define FRHA_ADDR_LOW_LSB 0
`define FRHA_ADDR_LOW_MSB 15
`define FRHA_ADDR_HIGH_LSB 0
`define FRHA_ADDR_HIGH_MSB 3
`define FRHA_SELECT_BIT 4
`define FRHA_WRITE_BIT 5
`define FRHA_DLMODE_LSB 6
`define FRHA_DLMODE_MSB 7
`define FRHA_DATA_LSB 8
`define FRHA_DATA_MSB 15
`define FRHA_ADDR_LOW_RST 16'h0000
`define FRHA_ADDR_HIGH_RST 4'h0
`define FRHA_DATA_RST 8'h00
`define FRHA_DLMODE_RST 2'h0
`define FRHA_SELECT_RST 1'b0
`define FRHA_RESP_OKAY 2'b00
`define FRHA_RESP_SLVERR 2'b10
`define FRHA_STROBE_NS 16
`define FRHA_CLK_NS 8
`endif

// File: logic/frha_store_port.v
`timescale 1ns/1ps
// Drives the store strobes: a read enable held high after reset, even during a write pulse of fixed length
module frha_store_port #(
   parameter STROBE_CYCLES = 2
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Request
   input wire write_start,
   output wire busy,
   // Store pins
   output reg store_write_en_r,
   output reg store_read_en_r
);
   reg [7:0] count_r;

   assign busy = store_write_en_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         store_write_en_r <= 1'b0;
         store_read_en_r <= 1'b0;
         count_r <= 8'h00;
      end else begin
         store_read_en_r <= 1'b1;
         if (write_start && !store_write_en_r) begin
            store_write_en_r <= 1'b1;
            count_r <= STROBE_CYCLES[7:0];
         end else if (store_write_en_r) begin
            if (count_r == 8'h01) begin
               store_write_en_r <= 1'b0;
            end
            count_r <= count_r - 8'h01;
         end
      end
   end
endmodule // frha_store_port

// File: logic/frha_top.v
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "frha_regs.vh"
module frha_top #(
   parameter ADDR_W = 12
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Shared store address and data
   output wire [19:0] store_addr,
   output wire [7:0] store_wdata,
   input wire [7:0] rom_rdata,
   input wire [7:0] flash_rdata,
   // ROM strobes
   output wire rom_read_en,
   output wire rom_write_en,
   // Flash strobes
   output wire flash_read_en,
   output wire flash_write_en,
   // Configuration download source, 1 for flash
   output wire config_from_flash,
   // Store write in progress
   output wire store_busy
);
   localparam STROBE_CYCLES = (`FRHA_STROBE_NS + `FRHA_CLK_NS - 1) / `FRHA_CLK_NS;

   reg [15:0] store_address_low_r;
   reg [3:0] store_address_high_r;
   reg store_select_r;
   reg [1:0] download_mode_reserved_r;
   reg [7:0] data_byte_r;
   reg [ADDR_W-1:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg aw_held_r;
   reg w_held_r;
   reg [7:0] rom_sync1_r;
   reg [7:0] rom_sync2_r;
   reg [7:0] flash_sync1_r;
   reg [7:0] flash_sync2_r;
   reg write_start_r;
   wire write_en_w;
   wire read_en_w;
   wire do_write;
   wire [7:0] selected_rdata;

   function [31:0] frha_read_word;
      input [ADDR_W-1:0] addr;
      input [15:0] low;
      input [15:0] ctrl;
      begin
         frha_read_word = 32'h00000000;
         if (addr == `FRHA_ADDR_LOW_OFS) begin
            frha_read_word = {16'h0000, low};
         end else if (addr == `FRHA_CONTROL_OFS) begin
            frha_read_word = {16'h0000, ctrl};
         end
      end
   endfunction

   function mapped;
      input [ADDR_W-1:0] addr;
      begin
         mapped = (addr == `FRHA_ADDR_LOW_OFS) || (addr == `FRHA_CONTROL_OFS);
      end
   endfunction

   // Write channels are held independently and taken in any order
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   assign store_addr = {store_address_high_r, store_address_low_r}; // see [R2]
   assign store_wdata = data_byte_r;
   assign rom_write_en = write_en_w && !store_select_r; // see [R3]
   assign flash_write_en = write_en_w && store_select_r; // see [R3]
   assign rom_read_en = read_en_w && !store_select_r;
   assign flash_read_en = read_en_w && store_select_r;
   assign config_from_flash = store_select_r; // see [R4]
   assign selected_rdata = store_select_r ? flash_sync2_r : rom_sync2_r; // see [R3]

   frha_store_port #(
      .STROBE_CYCLES(STROBE_CYCLES)
   ) u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .write_start(write_start_r),
      .busy(store_busy),
      .store_write_en_r(write_en_w),
      .store_read_en_r(read_en_w)
   );

   // Store read data crosses from the pins
   always @(posedge aclk) begin
      if (!aresetn) begin
         rom_sync1_r <= 8'h00;
         rom_sync2_r <= 8'h00;
         flash_sync1_r <= 8'h00;
         flash_sync2_r <= 8'h00;
      end else begin
         rom_sync1_r <= rom_rdata;
         rom_sync2_r <= rom_sync1_r;
         flash_sync1_r <= flash_rdata;
         flash_sync2_r <= flash_sync1_r;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= {ADDR_W{1'b0}};
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FRHA_RESP_OKAY;
         store_address_low_r <= `FRHA_ADDR_LOW_RST;
         store_address_high_r <= `FRHA_ADDR_HIGH_RST;
         store_select_r <= `FRHA_SELECT_RST;
         download_mode_reserved_r <= `FRHA_DLMODE_RST;
         data_byte_r <= `FRHA_DATA_RST;
         write_start_r <= 1'b0;
      end else begin
         write_start_r <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awaddr_r) ? `FRHA_RESP_OKAY : `FRHA_RESP_SLVERR;
            if (awaddr_r == `FRHA_ADDR_LOW_OFS) begin
               if (wstrb_r[0]) begin
                  store_address_low_r[7:0] <= wdata_r[7:0]; // see [R1]
               end
               if (wstrb_r[1]) begin
                  store_address_low_r[15:8] <= wdata_r[15:8]; // see [R1]
               end
            end else if (awaddr_r == `FRHA_CONTROL_OFS) begin
               // Fields frozen while a store write runs
               if (wstrb_r[0] && !store_busy) begin
                  store_address_high_r <= wdata_r[`FRHA_ADDR_HIGH_MSB:`FRHA_ADDR_HIGH_LSB]; // see [R2]
                  store_select_r <= wdata_r[`FRHA_SELECT_BIT]; // see [R3]
                  download_mode_reserved_r <= wdata_r[`FRHA_DLMODE_MSB:`FRHA_DLMODE_LSB]; // see [R8]
                  write_start_r <= wdata_r[`FRHA_WRITE_BIT]; // see [R5]
               end
               if (wstrb_r[1] && !store_busy) begin
                  data_byte_r <= wdata_r[`FRHA_DATA_MSB:`FRHA_DATA_LSB]; // see [R6]
               end
            end
         end
      end
   end

   // Reads return the stored byte while a store write runs, else the store byte
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `FRHA_RESP_OKAY;
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `FRHA_RESP_OKAY : `FRHA_RESP_SLVERR;
            s_axi_rdata <= frha_read_word(s_axi_araddr, store_address_low_r,
               {(store_busy ? data_byte_r : selected_rdata), download_mode_reserved_r,
                1'b0, store_select_r, store_address_high_r}); // see [R6]
         end
      end
   end
endmodule // frha_top

// File: bench/frha_store_model.sv
`timescale 1ns/1ps
// Byte-wide ROM and flash; a store not being read shows the inverse of its last byte
module frha_store_model (
   // Clock
   input wire aclk,
   // Shared address and data
   input wire [19:0] store_addr,
   input wire [7:0] store_wdata,
   // Strobes
   input wire rom_read_en,
   input wire rom_write_en,
   input wire flash_read_en,
   input wire flash_write_en,
   // Read bytes
   output logic [7:0] rom_rdata = 8'h00,
   output logic [7:0] flash_rdata = 8'h00
);
   logic [7:0] rom_m [int];
   logic [7:0] fl_m [int];
   always @(posedge aclk) begin
      if (rom_write_en) rom_m[store_addr] = store_wdata;
      if (flash_write_en) fl_m[store_addr] = store_wdata;
      // Unwritten bytes: the ROM holds the low address byte, the flash its inverse
      rom_rdata <= !rom_read_en ? ~rom_rdata :
                   rom_m.exists(store_addr) ? rom_m[store_addr] : store_addr[7:0];
      flash_rdata <= !flash_read_en ? ~flash_rdata :
                     fl_m.exists(store_addr) ? fl_m[store_addr] : ~store_addr[7:0];
   end
endmodule // frha_store_model

// File: bench/frha_top_sva.sv
`timescale 1ns/1ps
module frha_top_sva (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Bus handshakes
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   // Store side
   input wire [19:0] store_addr,
   input wire [7:0] store_wdata,
   input wire rom_read_en,
   input wire rom_write_en,
   input wire flash_read_en,
   input wire flash_write_en,
   input wire config_from_flash,
   input wire store_busy
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   one_reader_a: assert property (!(rom_read_en && flash_read_en))
      else $error("both stores read");
   rom_route_a: assert property (
      (rom_read_en || rom_write_en) |-> !config_from_flash)
      else $error("rom access with flash selected");
   flash_route_a: assert property (
      (flash_read_en || flash_write_en) |-> config_from_flash)
      else $error("flash access with rom selected");
   rom_pulse_a: assert property (
      $rose(rom_write_en) |=> rom_write_en ##1 !rom_write_en)
      else $error("rom write pulse length");
   flash_pulse_a: assert property (
      $rose(flash_write_en) |=> flash_write_en ##1 !flash_write_en)
      else $error("flash write pulse length");
   // The response goes out on the edge that also launches the start pulse
   write_cause_a: assert property ($rose(rom_write_en || flash_write_en) |->
      $past(s_axi_bvalid) && store_busy) else $error("store write without request");
   held_fields_a: assert property (store_busy && $past(store_busy) |->
      $stable(store_wdata) && $stable(store_addr[19:16]) && $stable(config_from_flash))
      else $error("fields changed during store write");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
endmodule // frha_top_sva
bind frha_top frha_top_sva u_frha_sva (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .store_addr, .store_wdata,
   .rom_read_en, .rom_write_en, .flash_read_en, .flash_write_en, .config_from_flash,
   .store_busy);

// File: bench/tb_flash_rom_host_access.sv
`timescale 1ns/1ps
module tb_flash_rom_host_access;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, r = 32'hA466;
   logic [3:0] s_axi_wstrb = 4'hF, hi;
   logic [15:0] lo;
   logic [7:0] d;
   logic [1:0] dm;
   logic [7:0] sh [int];
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, store_busy;
   wire rom_read_en, rom_write_en, flash_read_en, flash_write_en, config_from_flash;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [19:0] store_addr;
   wire [7:0] store_wdata, rom_rdata, flash_rdata;
   int miscompares = 0, cmp_count = 0, cyc = 0, i;
   always #4 aclk = ~aclk;
   frha_top #(.ADDR_W(12)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .store_addr, .store_wdata, .rom_rdata, .flash_rdata,
      .rom_read_en, .rom_write_en, .flash_read_en, .flash_write_en, .config_from_flash,
      .store_busy);
   frha_store_model u_mem (.aclk, .store_addr, .store_wdata, .rom_read_en, .rom_write_en,
      .flash_read_en, .flash_write_en, .rom_rdata, .flash_rdata);
   function automatic [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic [7:0] exp_byte(input sel, input [19:0] a);
      exp_byte = sh.exists({sel, a}) ? sh[{sel, a}] : (sel ? ~a[7:0] : a[7:0]);
   endfunction
   task automatic chk(input string nm, input [31:0] got, input [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input [11:0] a, input [31:0] v, input [3:0] st, input [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      chk("bresp", s_axi_bresp, er);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rdchk(input [11:0] a, input [31:0] ev, input [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      chk("rdata", s_axi_rdata, ev);
      chk("rresp", s_axi_rresp, er);
      s_axi_rready <= 1'h0;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         give_verdict;
      end
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (4) @(posedge aclk);
      rdchk(12'h000, 32'h0, 2'h0);
      rdchk(12'h004, 32'h0, 2'h0);
      $display("reset test done");
      // This maintenance sequence and the corner test's address-low write touch the store fields
      for (i = 0; i < 12; i++) begin
         r = lfsr(r);
         lo = r[15:0];
         wr(12'h000, r, 4'hF, 2'h0);
         r = lfsr(r);
         {d, dm, s, hi} = {r[15:8], r[7:6], r[4], r[3:0]};
         wr(12'h004, {r[31:16], d, dm, 1'h1, s, hi}, 4'hF, 2'h0);
         sh[{s, hi, lo}] = d;
         repeat (8) @(posedge aclk);
         chk("store_addr", store_addr, {hi, lo});
         chk("config_src", config_from_flash, s);
         rdchk(12'h004, {16'h0, d, dm, 1'h0, s, hi}, 2'h0);
         rdchk(12'h000, {16'h0, lo}, 2'h0);
         wr(12'h004, {16'h0, d, dm, 1'h0, ~s, hi}, 4'hF, 2'h0);
         repeat (8) @(posedge aclk);
         rdchk(12'h004, {16'h0, exp_byte(~s, {hi, lo}), dm, 1'h0, ~s, hi}, 2'h0);
      end
      $display("random test done");
      wr(12'h000, 32'h00005A00, 4'h2, 2'h0);
      rdchk(12'h000, {16'h0, 8'h5A, lo[7:0]}, 2'h0);
      wr(12'h008, 32'hFFFFFFFF, 4'hF, 2'h2);
      rdchk(12'h008, 32'h0, 2'h2);
      $display("corner test done");
      give_verdict;
   end
endmodule // tb_flash_rom_host_access
